// ==== logic/counter_consts.vh ====
/*
 * Constants of the counter readout and gate control block: register map,
 * field positions, reset values, function codes and timing figures.
 * Assumes inclusion by its bare name from the design file, once per unit.
 */
`ifndef COUNTER_CONSTS_VH
`define COUNTER_CONSTS_VH
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_COUNT 8'h08
`define CTRL_RESET 32'h00000000
`define CTRL_MASK 32'h0001FFFF
`define CTRL_FUNC_LSB 0
`define CTRL_RANGE_LSB 4
`define CTRL_SLOPE_A 8
`define CTRL_SLOPE_B 9
`define CTRL_DTIME_LSB 10
`define CTRL_JUMPER 14
`define CTRL_MANUAL 15
`define CTRL_RESET_BTN 16
`define ST_GATE 0
`define ST_OVERFLOW 1
`define ST_STATE_LSB 2
`define ST_DEC_LSB 4
`define ST_UNIT_LSB 8
`define FN_RATE_A 4'h0
`define FN_CYCLE_B 4'h1
`define FN_SPAN_B 4'h2
`define FN_A_TO_B 4'h3
`define FN_CYCLE_B_AVG 4'h4
`define FN_SPAN_B_AVG 4'h5
`define FN_A_TO_B_AVG 4'h6
`define FN_QUOTIENT_AB 4'h7
`define FN_GATED_TALLY 4'h8
`define FN_SHARED 4'h9
`define UNIT_NONE 4'h0
`define UNIT_HZ 4'h1
`define UNIT_KHZ 4'h2
`define UNIT_MHZ 4'h4
`define UNIT_GHZ 4'h8
`define RANGE_MAX 4'h8
`define DTIME_HOLD 4'hF
`define CLK_NS 20
`define TB_BASE_NS 100
`define HOLDOFF_MS 100
`endif

// ==== logic/counter_display_and_gate_control.v ====
/*
 * Gate control, decade counter and readout decode of an eight digit
 * counter/timer, with its front-panel settings held in an APB register.
 * Assumes shaped channel triggers synchronous to pclk and an APB master
 * that holds each request until it samples pready high.
 */
`timescale 1ns/1ns
`include "counter_consts.vh"
module counter_display_and_gate_control #(
    parameter HOLDOFF_CYCLES = `HOLDOFF_MS * 1000000 / `CLK_NS,
    parameter DIGITS = 8
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire trig_a,
    input wire trig_b,
    output reg [4*DIGITS-1:0] digit_bcd,
    output reg [DIGITS-1:0] digit_blank,
    output reg [DIGITS-1:0] digit_point,
    output reg [3:0] unit_lamp,
    output reg gate_lamp,
    output reg overflow_lamp
);
    localparam [1:0] S_HOLD = 2'h0;
    localparam [1:0] S_ARM = 2'h1;
    localparam [1:0] S_OPEN = 2'h2;
    localparam [1:0] K_NOW = 2'h0;
    localparam [1:0] K_PER = 2'h1;
    localparam [1:0] K_WID = 2'h2;
    localparam [1:0] K_AB = 2'h3;
    localparam [31:0] TB_BASE = (`TB_BASE_NS + `CLK_NS - 1) / `CLK_NS;
    localparam [31:0] HOLD_BASE = HOLDOFF_CYCLES;

    reg [31:0] ctrl;
    reg [4*DIGITS-1:0] bcd;
    reg overflow;
    reg gate;
    reg [1:0] state;
    reg [31:0] hold_cnt;
    reg [31:0] n_cnt;
    reg [31:0] pre;
    reg a_q;
    reg b_q;

    wire [3:0] func = ctrl[`CTRL_FUNC_LSB+3:`CTRL_FUNC_LSB];
    wire [3:0] rng_raw = ctrl[`CTRL_RANGE_LSB+3:`CTRL_RANGE_LSB];
    wire [3:0] rng = (rng_raw > `RANGE_MAX) ? `RANGE_MAX : rng_raw;
    wire slope_a = ctrl[`CTRL_SLOPE_A];
    wire slope_b = ctrl[`CTRL_SLOPE_B];
    wire [3:0] dtime = ctrl[`CTRL_DTIME_LSB+3:`CTRL_DTIME_LSB];
    wire jumper_tally = ctrl[`CTRL_JUMPER];
    wire manual_gate_button = ctrl[`CTRL_MANUAL];
    wire reset_button = ctrl[`CTRL_RESET_BTN];

    wire ev_a = slope_a ? (a_q & ~trig_a) : (trig_a & ~a_q);
    wire ev_b = slope_b ? (b_q & ~trig_b) : (trig_b & ~b_q);
    wire evx_b = slope_b ? (trig_b & ~b_q) : (b_q & ~trig_b);
    wire shared = (func == `FN_SHARED);
    wire tally = shared & jumper_tally;
    wire manual = shared & ~jumper_tally;
    wire avg_mode = (func == `FN_CYCLE_B_AVG) || (func == `FN_SPAN_B_AVG) ||
        (func == `FN_A_TO_B_AVG);

    function [31:0] pow10;
        input [3:0] r;
        integer i;
        begin
            pow10 = 32'h00000001;
            for (i = 0; i < 8; i = i + 1) begin
                if (i < r) begin
                    pow10 = pow10 * 32'h0000000A;
                end
            end
        end
    endfunction

    // Avg modes time with the finest clock; the others with the range clock.
    wire [31:0] tb = avg_mode ? TB_BASE : TB_BASE * pow10(rng);
    wire tick = gate && (pre == tb - 32'h00000001);

    reg [1:0] kind;
    reg [31:0] n_limit;
    reg inc_src;
    always @* begin
        kind = K_NOW;
        n_limit = 32'h00000001;
        inc_src = 1'b0;
        case (func)
            `FN_RATE_A: begin
                inc_src = ev_a;
            end
            `FN_CYCLE_B, `FN_CYCLE_B_AVG: begin
                kind = K_PER;
                inc_src = tick;
            end
            `FN_SPAN_B, `FN_SPAN_B_AVG: begin
                kind = K_WID;
                inc_src = tick;
            end
            `FN_A_TO_B, `FN_A_TO_B_AVG: begin
                kind = K_AB;
                inc_src = tick;
            end
            `FN_QUOTIENT_AB: begin
                kind = K_PER;
                inc_src = ev_a;
                n_limit = pow10(rng);
            end
            `FN_GATED_TALLY: begin
                kind = K_WID;
                inc_src = ev_a;
                n_limit = pow10(rng);
            end
            `FN_SHARED: begin
                inc_src = tally ? ev_a : tick;
            end
            default: inc_src = 1'b0;
        endcase
        if (avg_mode) begin
            n_limit = pow10(rng);
        end
    end

    wire start_ev = (kind == K_NOW) ? 1'b1 : ((kind == K_AB) ? ev_a : ev_b);
    wire stop_ev = (kind == K_NOW) ? tick : ((kind == K_WID) ? evx_b : ev_b);
    wire [31:0] hold_target = HOLD_BASE * ({28'h0000000, dtime} + 32'h00000001);
    wire hold_done = (state == S_HOLD) && (dtime != `DTIME_HOLD) &&
        (hold_cnt >= hold_target - 32'h00000001);
    wire new_meas = hold_done && !shared;
    wire clr = reset_button | new_meas;
    wire inc_now = gate & inc_src & ~reset_button;
    wire last_n = (n_cnt + 32'h00000001) >= n_limit;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            a_q <= 1'b0;
            b_q <= 1'b0;
        end else begin
            a_q <= trig_a;
            b_q <= trig_b;
        end
    end

    // Main gate sequencing; the shared position bypasses hold-off entirely.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= S_HOLD;
            gate <= 1'b0;
            hold_cnt <= 32'h00000000;
            n_cnt <= 32'h00000000;
        end else if (reset_button) begin
            state <= S_ARM;
            gate <= 1'b0;
            hold_cnt <= 32'h00000000;
            n_cnt <= 32'h00000000;
        end else if (shared) begin
            state <= S_HOLD;
            gate <= manual_gate_button;
            hold_cnt <= 32'h00000000;
            n_cnt <= 32'h00000000;
        end else begin
            case (state)
                S_HOLD: begin
                    gate <= 1'b0;
                    if (dtime == `DTIME_HOLD) begin
                        hold_cnt <= 32'h00000000;
                    end else if (hold_done) begin
                        hold_cnt <= 32'h00000000;
                        state <= S_ARM;
                    end else begin
                        hold_cnt <= hold_cnt + 32'h00000001;
                    end
                end
                S_ARM: begin
                    if (start_ev) begin
                        state <= S_OPEN;
                        gate <= 1'b1;
                    end
                end
                S_OPEN: begin
                    if (stop_ev) begin
                        if (last_n) begin
                            state <= S_HOLD;
                            gate <= 1'b0;
                            n_cnt <= 32'h00000000;
                        end else begin
                            n_cnt <= n_cnt + 32'h00000001;
                            if (kind != K_PER) begin
                                state <= S_ARM;
                                gate <= 1'b0;
                            end
                        end
                    end
                end
                default: begin
                    state <= S_HOLD;
                    gate <= 1'b0;
                end
            endcase
        end
    end

    // Timebase prescaler restarts whenever the gate is closed.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre <= 32'h00000000;
        end else if (!gate || tick) begin
            pre <= 32'h00000000;
        end else begin
            pre <= pre + 32'h00000001;
        end
    end

    wire [DIGITS:0] carry;
    assign carry[0] = inc_now;
    genvar g;
    generate
        for (g = 0; g < DIGITS; g = g + 1) begin : decade
            wire [3:0] d = bcd[4*g+3:4*g];
            assign carry[g+1] = carry[g] & (d == 4'h9);
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    bcd[4*g+3:4*g] <= 4'h0;
                end else if (clr) begin
                    bcd[4*g+3:4*g] <= 4'h0;
                end else if (carry[g]) begin
                    bcd[4*g+3:4*g] <= (d == 4'h9) ? 4'h0 : d + 4'h1;
                end
            end
        end
    endgenerate

    // A wrap in the same cycle as a clear still leaves the flag set.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overflow <= 1'b0;
        end else if (carry[DIGITS]) begin
            overflow <= 1'b1;
        end else if (reset_button) begin
            overflow <= 1'b0;
        end
    end

    reg [3:0] decimals;
    reg [3:0] units;
    always @* begin
        decimals = 4'h0;
        units = `UNIT_NONE;
        case (func)
            `FN_RATE_A: begin
                if (rng == 4'h0) begin
                    units = `UNIT_GHZ;
                    decimals = 4'h2;
                end else if (rng <= 4'h5) begin
                    units = `UNIT_MHZ;
                    decimals = rng - 4'h1;
                end else begin
                    units = `UNIT_KHZ;
                    decimals = rng - 4'h4;
                end
            end
            `FN_CYCLE_B, `FN_SPAN_B, `FN_A_TO_B: begin
                if (rng == 4'h0) begin
                    units = `UNIT_MHZ;
                    decimals = 4'h1;
                end else if (rng <= 4'h3) begin
                    units = `UNIT_KHZ;
                    decimals = 4'h4 - rng;
                end else if (rng <= 4'h7) begin
                    units = `UNIT_HZ;
                    decimals = 4'h7 - rng;
                end else begin
                    decimals = 4'h2;
                end
            end
            `FN_CYCLE_B_AVG, `FN_SPAN_B_AVG, `FN_A_TO_B_AVG: begin
                if (rng <= 4'h2) begin
                    units = `UNIT_KHZ;
                    decimals = 4'h4 + rng;
                end else if (rng <= 4'h5) begin
                    units = `UNIT_MHZ;
                    decimals = 4'h1 + rng;
                end else begin
                    units = `UNIT_GHZ;
                    decimals = rng - 4'h2;
                end
            end
            `FN_QUOTIENT_AB, `FN_GATED_TALLY: begin
                decimals = (rng == `RANGE_MAX) ? 4'h0 : rng;
            end
            `FN_SHARED: begin
                if (manual) begin
                    decimals = (rng == 4'h0) ? 4'h1 : 4'h0;
                    units = (rng == 4'h0) ? `UNIT_MHZ : `UNIT_HZ;
                end else begin
                    decimals = 4'h0;
                    units = `UNIT_NONE;
                end
            end
            default: begin
                decimals = 4'h0;
                units = `UNIT_NONE;
            end
        endcase
    end

    // Leading zero suppression stops at the point so 0.00 keeps its zeros.
    reg [DIGITS-1:0] next_blank;
    reg [DIGITS-1:0] next_point;
    reg seen;
    integer k;
    always @* begin
        seen = 1'b0;
        next_blank = {DIGITS{1'b0}};
        next_point = {DIGITS{1'b0}};
        for (k = DIGITS - 1; k >= 0; k = k - 1) begin
            seen = seen | (bcd[4*k+:4] != 4'h0) | (k <= decimals) | (k == 0);
            next_blank[k] = ~seen;
            next_point[k] = (decimals != 4'h0) && (k == decimals);
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            digit_bcd <= {4*DIGITS{1'b0}};
            digit_blank <= {DIGITS{1'b0}};
            digit_point <= {DIGITS{1'b0}};
            unit_lamp <= `UNIT_NONE;
            gate_lamp <= 1'b0;
            overflow_lamp <= 1'b0;
        end else begin
            if (reset_button) begin
                digit_bcd <= {DIGITS{4'h8}};
                digit_blank <= {DIGITS{1'b0}};
                digit_point <= {DIGITS{1'b1}};
            end else begin
                digit_bcd <= bcd;
                digit_blank <= next_blank;
                digit_point <= next_point;
            end
            unit_lamp <= units;
            gate_lamp <= gate;
            overflow_lamp <= overflow;
        end
    end

    // APB slave with one wait state so that read data comes from a flop.
    wire access = psel & penable;
    wire mapped = (paddr == `OFS_CTRL) || (paddr == `OFS_STATUS) ||
        (paddr == `OFS_COUNT);
    reg [31:0] rdata;
    wire [4*DIGITS+31:0] bcd_word = {32'h00000000, bcd};
    always @* begin
        rdata = 32'h00000000;
        case (paddr)
            `OFS_CTRL: begin
                rdata = ctrl;
            end
            `OFS_STATUS: begin
                rdata[`ST_GATE] = gate;
                rdata[`ST_OVERFLOW] = overflow;
                rdata[`ST_STATE_LSB+1:`ST_STATE_LSB] = state;
                rdata[`ST_DEC_LSB+3:`ST_DEC_LSB] = decimals;
                rdata[`ST_UNIT_LSB+3:`ST_UNIT_LSB] = units;
            end
            `OFS_COUNT: begin
                rdata = bcd_word[31:0];
            end
            default: rdata = 32'h00000000;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= `CTRL_RESET;
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= access & ~pready;
            if (access & ~pready) begin
                prdata <= pwrite ? 32'h00000000 : rdata;
                pslverr <= ~mapped;
            end else begin
                pslverr <= 1'b0;
            end
            if (access & pready & pwrite & (paddr == `OFS_CTRL)) begin
                ctrl <= pwdata & `CTRL_MASK;
            end
        end
    end
endmodule

// ==== bench/gate_readout_checker.sv ====
/*
 * Port checker for the counter readout and gate control block.
 * Assumes one clock domain and that CTRL sits at byte address zero.
 */
`timescale 1ns/1ns
module gate_readout_checker #(
    parameter HOLDOFF_CYCLES = 20,
    parameter DIGITS = 8
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire trig_a,
    input wire trig_b,
    input wire [4*DIGITS-1:0] digit_bcd,
    input wire [DIGITS-1:0] digit_blank,
    input wire [DIGITS-1:0] digit_point,
    input wire [3:0] unit_lamp,
    input wire gate_lamp,
    input wire overflow_lamp
);
    logic [16:0] ctrl_q;
    logic [3:0] settle;
    logic [3:0] quiet;
    logic trig_q;
    wire wr = psel && penable && pready && pwrite && paddr == 8'h00;
    wire tally = ctrl_q[14] && ctrl_q[3:0] == 4'h9 && !ctrl_q[16];
    wire counted = (trig_a && !trig_q && !ctrl_q[8]) || (!trig_a && trig_q && ctrl_q[8]);
    // Counters saturate so that long idle stretches keep the checks armed.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= 17'h0;
            settle <= 4'h0;
            quiet <= 4'h0;
            trig_q <= 1'h0;
        end else begin
            trig_q <= trig_a;
            if (wr) begin
                ctrl_q <= pwdata[16:0];
            end
            settle <= wr ? 4'h0 : (settle == 4'hF ? settle : settle + 4'h1);
            quiet <= (wr || counted) ? 4'h0 : (quiet == 4'hF ? quiet : quiet + 4'h1);
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence
    wire lamp_on = ctrl_q[16] && settle >= 4'h3;
    ready_one_cycle_a: assert property (pready |=> !pready)
        else $error("pready stood longer than one cycle");
    ready_wait_a: assert property (s_setup ##1 s_access |-> !pready ##1 pready)
        else $error("pready not after exactly one wait cycle");
    unmapped_err_a: assert property (pready |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08}))
        else $error("pslverr wrong for address");
    lamp_test_a: assert property (lamp_on |-> digit_bcd == {DIGITS{4'h8}} && digit_blank == 0)
        else $error("lamp test digits wrong");
    test_clears_ovf_a: assert property (lamp_on |-> !overflow_lamp)
        else $error("overflow lamp not cleared");
    ovf_sticky_a: assert property (overflow_lamp && !ctrl_q[16] |=> overflow_lamp)
        else $error("overflow lamp dropped");
    tally_dark_a: assert property (tally && settle >= 4'h3 |-> unit_lamp == 0 && digit_point == 0)
        else $error("tally lamps or points lit");
    tally_gate_a: assert property (tally && settle >= 4'h3 |-> gate_lamp == ctrl_q[15])
        else $error("tally gate lamp not following button");
    tally_edges_a: assert property (tally && quiet >= 4'h4 |-> $stable(digit_bcd))
        else $error("tally moved without a counted edge");
endmodule
bind counter_display_and_gate_control gate_readout_checker #(
    .HOLDOFF_CYCLES(HOLDOFF_CYCLES), .DIGITS(DIGITS)
) chk_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trig_a(trig_a), .trig_b(trig_b), .digit_bcd(digit_bcd), .digit_blank(digit_blank),
    .digit_point(digit_point), .unit_lamp(unit_lamp), .gate_lamp(gate_lamp),
    .overflow_lamp(overflow_lamp)
);

// ==== bench/trigger_source.sv ====
/*
 * Shaped channel trigger levels as the front end would present them.
 * Assumes callers enter drive just after a rising pclk edge.
 */
`timescale 1ns/1ns
module trigger_source (
    input wire pclk,
    output logic trig_a,
    output logic trig_b
);
    initial begin
        trig_a = 1'h0;
        trig_b = 1'h0;
    end
    // The shaper output is synchronous, so levels move only after an edge.
    task automatic drive(input logic a, input logic b, input int dly);
        begin
            repeat (dly) @(posedge pclk);
            trig_a <= a;
            trig_b <= b;
        end
    endtask
endmodule

// ==== bench/tb_top.sv ====
/*
 * Self-checking bench for the counter readout and gate control block.
 * Assumes the constants header and a hold-off unit of 20 cycles.
 */
`timescale 1ns/1ns
`include "counter_consts.vh"
module tb_top;
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] rd;
    logic [31:0] keep;
    logic rerr;
    int num_errors = 0;
    int tests_run = 0;
    int n0;
    int n3;
    int nh;
    wire [31:0] prdata;
    wire [31:0] digit_bcd;
    wire [7:0] digit_blank;
    wire [7:0] digit_point;
    wire [3:0] unit_lamp;
    wire pready, pslverr, trig_a, trig_b, gate_lamp, overflow_lamp;
    wire [7:0] wrap_bcd;
    wire wrap_ovf;
    // One nibble per range: rate, timing, averaging, quotient.
    logic [35:0] ut_tab [4] = '{36'h222444448, 36'h011112224, 36'h888444222, 36'h0};
    logic [35:0] dp_tab [4] = '{36'h432432102, 36'h201231231, 36'h654654654, 36'h076543210};
    counter_display_and_gate_control #(.HOLDOFF_CYCLES(20), .DIGITS(8)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .trig_a(trig_a), .trig_b(trig_b), .digit_bcd(digit_bcd),
        .digit_blank(digit_blank), .digit_point(digit_point), .unit_lamp(unit_lamp),
        .gate_lamp(gate_lamp), .overflow_lamp(overflow_lamp));
    // A two-decade copy reaches the top-decade wrap within a short run.
    counter_display_and_gate_control #(.HOLDOFF_CYCLES(20), .DIGITS(2)) wrap_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(), .trig_a(trig_a),
        .trig_b(trig_b), .digit_bcd(wrap_bcd), .digit_blank(), .digit_point(),
        .unit_lamp(), .gate_lamp(), .overflow_lamp(wrap_ovf));
    trigger_source src_u (.pclk(pclk), .trig_a(trig_a), .trig_b(trig_b));
    initial begin
        forever #10 pclk = ~pclk;
    end
    task automatic close_out;
        begin
            $display("errors %0d checks %0d", num_errors, tests_run);
            if (num_errors == 0 && tests_run > 0) begin
                $display("[ PASS ]");
            end else begin
                $display("[ FAIL ]");
            end
            $finish;
        end
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        begin
            tests_run++;
            if (got !== exp) begin
                num_errors++;
                $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        begin
            psel <= 1'h1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'h1;
            n = 0;
            do begin
                @(posedge pclk);
                n++;
            end while (pready !== 1'h1 && n < 16);
            if (n >= 16) begin
                num_errors++;
                close_out();
            end
            rd = prdata;
            rerr = pslverr;
            psel <= 1'h0;
            penable <= 1'h0;
            @(posedge pclk);
        end
    endtask
    // Flag bits: 0 slope_a falling, 1 jumper tally, 2 button in, 3 reset button.
    function automatic logic [31:0] cw(input logic [3:0] f, input logic [3:0] r,
                                       input logic [3:0] dt, input logic [3:0] b);
        cw = {15'h0, b[3], b[2], b[1], dt, 1'h0, b[0], r, f};
    endfunction
    task automatic setc(input logic [31:0] v);
        begin
            apb(1'h1, `OFS_CTRL, v);
            repeat (4) @(posedge pclk);
        end
    endtask
    task automatic step(input logic v, input logic [31:0] exp);
        begin
            src_u.drive(v, 1'h0, 1);
            repeat (4) @(posedge pclk);
            chk(digit_bcd, exp);
        end
    endtask
    task automatic rises(input int cyc, output int n);
        logic prev;
        begin
            n = 0;
            prev = gate_lamp;
            repeat (cyc) begin
                @(posedge pclk);
                if (gate_lamp && !prev) begin
                    n++;
                end
                prev = gate_lamp;
            end
        end
    endtask
    initial begin
        repeat (100000) @(posedge pclk);
        num_errors++;
        close_out();
    end
    initial begin
        int g;
        logic [3:0] ed;
        repeat (6) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        apb(1'h0, `OFS_CTRL, 32'h0);
        chk(rd, `CTRL_RESET);
        apb(1'h1, `OFS_CTRL, 32'hFFFFFFFF);
        apb(1'h0, `OFS_CTRL, 32'h0);
        chk(rd, `CTRL_MASK);
        apb(1'h0, 8'h0C, 32'h0);
        chk(32'(rerr), 32'h1);
        $display("test registers done");
        setc(cw(4'h0, 4'h0, 4'h0, 4'h8));
        chk(digit_bcd, 32'h88888888);
        chk(32'(digit_blank), 32'h0);
        $display("test lamp done");
        for (int f = 0; f < 9; f++) begin
            for (int r = 0; r < 9; r++) begin
                g = f == 0 ? 0 : (f < 4 ? 1 : (f < 7 ? 2 : 3));
                ed = dp_tab[g][r*4 +: 4];
                setc(cw(4'(f), 4'(r), 4'h0, 4'h0));
                if (g < 3) begin
                    chk(32'(unit_lamp), 32'(ut_tab[g][r*4 +: 4]));
                end
                chk(32'(digit_point), ed == 0 ? 32'h0 : 32'h1 << ed);
                chk(32'(digit_blank), 32'hFF & (32'hFE << ed));
            end
        end
        $display("test readout done");
        setc(cw(4'h9, 4'h0, 4'h0, 4'hA));
        setc(cw(4'h9, 4'h0, 4'h0, 4'h2));
        chk(digit_bcd, 32'h0);
        chk(32'(digit_blank), 32'hFE);
        setc(cw(4'h9, 4'h0, 4'h0, 4'h6));
        chk(32'(gate_lamp), 32'h1);
        step(1'h1, 32'h1);
        step(1'h0, 32'h1);
        step(1'h1, 32'h2);
        step(1'h0, 32'h2);
        setc(cw(4'h9, 4'h0, 4'h0, 4'hF));
        setc(cw(4'h9, 4'h0, 4'h0, 4'h7));
        chk(digit_bcd, 32'h0);
        step(1'h1, 32'h0);
        step(1'h0, 32'h1);
        step(1'h1, 32'h1);
        step(1'h0, 32'h2);
        setc(cw(4'h9, 4'h0, 4'h0, 4'h3));
        chk(32'(gate_lamp), 32'h0);
        step(1'h1, 32'h2);
        step(1'h0, 32'h2);
        $display("test tally done");
        setc(cw(4'h9, 4'h0, 4'h0, 4'h8));
        setc(cw(4'h9, 4'h0, 4'h0, 4'h4));
        repeat (100) @(posedge pclk);
        chk(32'(gate_lamp), 32'h1);
        chk(32'(digit_bcd != 32'h0), 32'h1);
        setc(cw(4'h9, 4'h0, 4'h0, 4'h0));
        chk(32'(gate_lamp), 32'h0);
        keep = digit_bcd;
        repeat (50) @(posedge pclk);
        chk(digit_bcd, keep);
        $display("test manual done");
        setc(cw(4'h0, 4'h0, 4'h0, 4'h0));
        rises(300, n0);
        setc(cw(4'h0, 4'h0, 4'h3, 4'h0));
        rises(300, n3);
        setc(cw(4'h0, 4'h0, 4'hF, 4'h0));
        rises(600, nh);
        chk(32'(n0 >= 8 && n0 <= 12), 32'h1);
        chk(32'(n3 >= 3 && n3 <= 4), 32'h1);
        chk(32'(nh <= 1), 32'h1);
        $display("test gate done");
        setc(cw(4'h1, 4'h0, 4'h0, 4'h0));
        repeat (30) @(posedge pclk);
        chk(32'(gate_lamp), 32'h0);
        src_u.drive(1'h0, 1'h1, 1);
        repeat (4) @(posedge pclk);
        chk(32'(gate_lamp), 32'h1);
        src_u.drive(1'h0, 1'h0, 1);
        repeat (4) @(posedge pclk);
        chk(32'(gate_lamp), 32'h1);
        src_u.drive(1'h0, 1'h1, 1);
        repeat (4) @(posedge pclk);
        chk(32'(gate_lamp), 32'h0);
        $display("test channel b done");
        setc(cw(4'h9, 4'h0, 4'h0, 4'h8));
        setc(cw(4'h9, 4'h0, 4'h0, 4'h4));
        repeat (600) @(posedge pclk);
        setc(cw(4'h9, 4'h0, 4'h0, 4'h0));
        chk(32'(wrap_ovf), 32'h1);
        chk(32'(overflow_lamp), 32'h0);
        keep = 32'(wrap_bcd);
        repeat (50) @(posedge pclk);
        chk(32'(wrap_bcd), keep);
        chk(32'(wrap_ovf), 32'h1);
        setc(cw(4'h9, 4'h0, 4'h0, 4'h8));
        chk(32'(wrap_ovf), 32'h0);
        setc(cw(4'h9, 4'h0, 4'h0, 4'h0));
        chk(32'(wrap_bcd), 32'h0);
        $display("test overflow done");
        close_out();
    end
endmodule
